// ### bdm_core.sv
// banked data memory: address forming, scratch ram, bank pointer, sfr port
// assumes the pipeline presents one instruction per four clocks, sampled in Q1
//
// What this block does
// - Data addresses are twelve bits wide, covering 4096 bytes.
// - Sixteen banks of 256 bytes; top four address bits pick the bank.
// - Only three full scratch banks exist, 768 bytes, plus the sfr area.
// - Any read of an unbuilt location returns zero.
// - Banked access joins bank pointer bits above the 8-bit operand.
// - Bank pointer keeps only four low bits; upper bits read zero.
// - Load-bank-literal writes the bank pointer directly from a literal.
// - Writes to unbuilt banks are dropped; reads from them give zero.
// - Status flags update even when the addressed bank is unbuilt.
// - File-to-file move uses full source and destination, no bank pointer.
// - Other instructions give an 8-bit offset resolved by pointer or window.
// - Window 00h-5Fh maps to bank 0, 60h-FFh to top of bank 15.
// - Window-select bit one: address from bank pointer and offset.
// - Window-select bit zero: quick window map, bank pointer ignored.
// - A window access finishes within one instruction cycle.
// - Extended mode bit set changes the window mapping.
// - Scratch ram begins at 000h at the bottom of bank 0.
// - Scratch ram is not cleared by any reset.
// - Special registers sit at F60h through FFFh.
// - Operand read happens in Q2, destination write in Q4.
module bdm_core
#(
   parameter int RAM_BYTES = bdm_pkg::GPR_BYTES
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // instruction from the pipeline, sampled in Q1
   input wire logic op_valid_i,
   input wire logic [7:0] op_offset_i,
   input wire logic op_bank_sel_i,
   input wire logic op_rd_i,
   input wire logic op_wr_i,
   input wire logic op_flags_i,
   input wire logic [7:0] op_wr_data_i,
   // file_to_file_move operands
   input wire logic file_to_file_move_i,
   input wire logic [11:0] move_src_addr_i,
   input wire logic [11:0] move_dst_addr_i,
   // load_bank_literal
   input wire logic load_bank_literal_i,
   input wire logic [7:0] bank_literal_i,
   // configuration
   input wire logic extended_instruction_enable_i,
   input wire logic [11:0] idx_base_i,
   // special_function_regs port
   input wire logic [7:0] sfr_rdata_i,
   output logic sfr_rd_o,
   output logic sfr_wr_o,
   output logic [11:0] sfr_addr_o,
   output logic [7:0] sfr_wdata_o,
   // results to the pipeline
   output logic [1:0] q_phase_o,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic [11:0] rd_addr_o,
   output logic flag_update_o,
   output logic unimpl_access_o,
   output logic [7:0] bank_pointer_reg_o
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   bdm_pkg::bdm_phase_t q_reg;
   bdm_pkg::bdm_phase_t q_next;
   logic inst_valid_reg;
   logic [7:0] inst_offset_reg;
   logic inst_bank_sel_reg;
   logic inst_rd_reg;
   logic inst_wr_reg;
   logic inst_flags_reg;
   logic [7:0] inst_wdata_reg;
   logic inst_move_reg;
   logic [11:0] inst_src_reg;
   logic [11:0] inst_dst_reg;
   logic inst_lbl_reg;
   logic [7:0] inst_lit_reg;
   logic [3:0] bank_pointer_bits;
   logic [3:0] bank_bits_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic [11:0] rd_addr_reg;
   logic rd_done_reg;
   logic unimpl_reg;
   logic unimpl_next;
   logic [11:0] src_addr;
   logic [11:0] dst_addr;
   logic in_q1;
   logic in_q2;
   logic in_q3;
   logic in_q4;
   logic rd_is_gpr;
   logic rd_is_sfr;
   logic rd_is_bank_ptr;
   logic wr_is_gpr;
   logic wr_is_sfr;
   logic wr_is_bank_ptr;
   logic do_read;
   logic do_write;
   logic ram_we;
   logic [9:0] ram_rd_idx;
   logic [9:0] ram_wr_idx;
   logic [7:0] ram_rd_data;
   logic [7:0] bank_ptr_view;
   logic [11:0] pre_src_addr;
   logic [11:0] sfr_addr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // quarter phase sequencer
   assign in_q1 = q_reg == bdm_pkg::BDM_Q1;
   assign in_q2 = q_reg == bdm_pkg::BDM_Q2;
   assign in_q3 = q_reg == bdm_pkg::BDM_Q3;
   assign in_q4 = q_reg == bdm_pkg::BDM_Q4;

   always_comb
   begin
      unique case (q_reg)
         bdm_pkg::BDM_Q1: q_next = bdm_pkg::BDM_Q2;
         bdm_pkg::BDM_Q2: q_next = bdm_pkg::BDM_Q3;
         bdm_pkg::BDM_Q3: q_next = bdm_pkg::BDM_Q4;
         bdm_pkg::BDM_Q4: q_next = bdm_pkg::BDM_Q1;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q_reg <= bdm_pkg::BDM_Q1;
      end
      else
      begin
         q_reg <= q_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction latch, taken at the end of Q1
   // latching lets the pipeline move on to its next fetch freely
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         inst_valid_reg <= 1'b0;
         inst_offset_reg <= 8'h00;
         inst_bank_sel_reg <= 1'b0;
         inst_rd_reg <= 1'b0;
         inst_wr_reg <= 1'b0;
         inst_flags_reg <= 1'b0;
         inst_wdata_reg <= 8'h00;
         inst_move_reg <= 1'b0;
         inst_src_reg <= 12'h000;
         inst_dst_reg <= 12'h000;
         inst_lbl_reg <= 1'b0;
         inst_lit_reg <= 8'h00;
      end
      else if (in_q1)
      begin
         inst_valid_reg <= op_valid_i;
         inst_offset_reg <= op_offset_i;
         inst_bank_sel_reg <= op_bank_sel_i;
         inst_rd_reg <= op_valid_i && op_rd_i;
         inst_wr_reg <= op_valid_i && op_wr_i;
         inst_flags_reg <= op_valid_i && op_flags_i;
         inst_wdata_reg <= op_wr_data_i;
         inst_move_reg <= file_to_file_move_i;
         inst_src_reg <= move_src_addr_i;
         inst_dst_reg <= move_dst_addr_i;
         inst_lbl_reg <= op_valid_i && load_bank_literal_i;
         inst_lit_reg <= bank_literal_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address forming: source for the read, destination for the write
   bdm_addr_gen u_src_addr
   (
      .offset_i(inst_offset_reg),
      .bank_mode_i(inst_bank_sel_reg),
      .full_mode_i(inst_move_reg),
      .full_addr_i(inst_src_reg),
      .bank_bits_i(bank_pointer_bits),
      .ext_en_i(extended_instruction_enable_i),
      .idx_base_i(idx_base_i),
      .addr_o(src_addr)
   );

   bdm_addr_gen u_dst_addr
   (
      .offset_i(inst_offset_reg),
      .bank_mode_i(inst_bank_sel_reg),
      .full_mode_i(inst_move_reg),
      .full_addr_i(inst_dst_reg),
      .bank_bits_i(bank_pointer_bits),
      .ext_en_i(extended_instruction_enable_i),
      .idx_base_i(idx_base_i),
      .addr_o(dst_addr)
   );

   // source formed from the raw operand ahead of the latch,
   // so the sfr address can leave a flip-flop already in Q2
   bdm_addr_gen u_pre_addr
   (
      .offset_i(op_offset_i),
      .bank_mode_i(op_bank_sel_i),
      .full_mode_i(file_to_file_move_i),
      .full_addr_i(move_src_addr_i),
      .bank_bits_i(bank_pointer_bits),
      .ext_en_i(extended_instruction_enable_i),
      .idx_base_i(idx_base_i),
      .addr_o(pre_src_addr)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sfr address: source taken at the end of Q1, destination at the end of Q3
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sfr_addr_reg <= 12'h000;
      end
      else if (in_q1)
      begin
         sfr_addr_reg <= pre_src_addr;
      end
      else if (in_q3)
      begin
         sfr_addr_reg <= dst_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // region decode over the 12-bit space
   // banks 3..14 and F00h-F5Fh fall through every decode
   assign rd_is_gpr = src_addr <= bdm_pkg::GPR_TOP;
   assign rd_is_bank_ptr = src_addr == bdm_pkg::BANK_PTR_ADDR;
   assign rd_is_sfr = (src_addr >= bdm_pkg::SFR_BASE) && !rd_is_bank_ptr;
   assign wr_is_gpr = dst_addr <= bdm_pkg::GPR_TOP;
   assign wr_is_bank_ptr = dst_addr == bdm_pkg::BANK_PTR_ADDR;
   assign wr_is_sfr = (dst_addr >= bdm_pkg::SFR_BASE) && !wr_is_bank_ptr;

   assign do_read = in_q2 && inst_rd_reg;
   assign do_write = in_q4 && inst_wr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // scratch ram
   assign ram_rd_idx = src_addr[9:0];
   assign ram_wr_idx = dst_addr[9:0];
   assign ram_we = do_write && wr_is_gpr;

   bdm_gpr_ram #(
      .DEPTH(RAM_BYTES)
   ) u_ram
   (
      .core_clk_i(core_clk_i),
      .wr_en_i(ram_we),
      .wr_idx_i(ram_wr_idx),
      .wr_data_i(inst_wdata_reg),
      .rd_idx_i(ram_rd_idx),
      .rd_data_o(ram_rd_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bank pointer: four live bits, upper nibble fixed at zero
   assign bank_ptr_view = {bdm_pkg::BANK_PTR_UNUSED, bank_pointer_bits};

   // literal load wins over a data write to the same register
   assign bank_bits_next = (in_q4 && inst_lbl_reg) ? inst_lit_reg[3:0] :
                           (do_write && wr_is_bank_ptr) ? inst_wdata_reg[3:0] :
                           bank_pointer_bits;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bank_pointer_bits <= bdm_pkg::BANK_PTR_RST;
      end
      else
      begin
         bank_pointer_bits <= bank_bits_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand read, captured at the end of Q2
   assign rd_data_next = rd_is_gpr ? ram_rd_data :
                         rd_is_bank_ptr ? bank_ptr_view :
                         rd_is_sfr ? sfr_rdata_i : 8'h00;

   assign unimpl_next = do_read ? !(rd_is_gpr || rd_is_sfr || rd_is_bank_ptr) :
                        (do_write && !(wr_is_gpr || wr_is_sfr || wr_is_bank_ptr));

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rd_data_reg <= 8'h00;
         rd_addr_reg <= 12'h000;
         rd_done_reg <= 1'b0;
      end
      else
      begin
         if (do_read)
         begin
            rd_data_reg <= rd_data_next;
            rd_addr_reg <= src_addr;
         end
         rd_done_reg <= do_read;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         unimpl_reg <= 1'b0;
      end
      else if (do_read || do_write)
      begin
         unimpl_reg <= unimpl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign q_phase_o = q_reg;
   assign rd_data_o = rd_data_reg;
   assign rd_valid_o = rd_done_reg;
   assign rd_addr_o = rd_addr_reg;
   assign unimpl_access_o = unimpl_reg;
   assign bank_pointer_reg_o = bank_ptr_view;

   // flags follow the operation, never the decode outcome
   assign flag_update_o = in_q4 && inst_flags_reg;

   // the sfr port sees only F60h-FFFh, bank pointer excluded
   assign sfr_rd_o = do_read && rd_is_sfr;
   assign sfr_wr_o = do_write && wr_is_sfr;
   assign sfr_addr_o = sfr_addr_reg;
   assign sfr_wdata_o = inst_wdata_reg;
endmodule

// ### bdm_pkg.sv
// constants, address map and phase type of the banked data memory block
// assumes one core clock; four clocks form one instruction cycle
package bdm_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int BANK_W = 4;
   localparam int OFS_W = 8;
   localparam int NUM_BANKS = 16;
   localparam int BANK_SIZE = 256;
   localparam int GPR_BANKS = 3;
   localparam int GPR_BYTES = 768;
   localparam int GPR_IDX_W = 10;

   ////////////////////////////////////////////////////////////////////////////
   // data address map
   localparam logic [11:0] GPR_BASE = 12'h000;
   localparam logic [11:0] GPR_TOP = 12'h2FF;
   localparam logic [11:0] SFR_BASE = 12'hF60;
   localparam logic [11:0] SFR_TOP = 12'hFFF;
   localparam logic [11:0] BANK_PTR_ADDR = 12'hFE0;

   ////////////////////////////////////////////////////////////////////////////
   // quick-access window
   localparam logic [7:0] WIN_SPLIT = 8'h60;
   localparam logic [3:0] WIN_LOW_BANK = 4'h0;
   localparam logic [3:0] WIN_HIGH_BANK = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // bank pointer layout and reset
   localparam int BANK_PTR_LSB = 0;
   localparam logic [3:0] BANK_PTR_RST = 4'h0;
   localparam logic [3:0] BANK_PTR_UNUSED = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // quarter phases of an instruction cycle
   typedef enum logic [1:0] {
      BDM_Q1 = 2'b00,
      BDM_Q2 = 2'b01,
      BDM_Q3 = 2'b10,
      BDM_Q4 = 2'b11
   } bdm_phase_t;
endpackage

// ### bdm_addr_gen.sv
// forms one 12-bit data address from an instruction operand
// assumes operands held stable by the caller; purely combinational
module bdm_addr_gen
(
   // operand
   input wire logic [7:0] offset_i,
   input wire logic bank_mode_i,
   input wire logic full_mode_i,
   input wire logic [11:0] full_addr_i,
   // context
   input wire logic [3:0] bank_bits_i,
   input wire logic ext_en_i,
   input wire logic [11:0] idx_base_i,
   // result
   output logic [11:0] addr_o
);
   logic win_low;
   logic [11:0] banked_addr;
   logic [11:0] win_addr;
   logic [11:0] idx_addr;

   assign win_low = offset_i < bdm_pkg::WIN_SPLIT;
   assign banked_addr = {bank_bits_i, offset_i};
   // low window offsets land in bank 0, high ones at top of bank 15
   assign win_addr = win_low ? {bdm_pkg::WIN_LOW_BANK, offset_i}
                             : {bdm_pkg::WIN_HIGH_BANK, offset_i};
   // extended mode: low window becomes relative to the index base
   assign idx_addr = idx_base_i + {4'h0, offset_i};
   assign addr_o = full_mode_i ? full_addr_i :
                   bank_mode_i ? banked_addr :
                   (ext_en_i && win_low) ? idx_addr : win_addr;
endmodule

// ### bdm_gpr_ram.sv
// general scratch ram, three banks starting at address zero
// assumes index already range-checked; contents have no reset
module bdm_gpr_ram
#(
   parameter int DEPTH = bdm_pkg::GPR_BYTES
)
(
   // clock
   input wire logic core_clk_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [9:0] wr_idx_i,
   input wire logic [7:0] wr_data_i,
   // read port
   input wire logic [9:0] rd_idx_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem [DEPTH];

   // no reset: contents survive every reset and power up unknown
   always_ff @(posedge core_clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_idx_i] <= wr_data_i;
      end
   end

   assign rd_data_o = mem[rd_idx_i];
endmodule

// ### bdm_sfr_model.sv
// behavioural model of the special register space behind the block
// assumes the block's strobes and address are settled in Q2 and Q4
module bdm_sfr_model
(
   // clock
   input wire logic core_clk_i,
   // special register port of the block
   input wire logic sfr_rd_i,
   input wire logic sfr_wr_i,
   input wire logic [11:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:159];
   logic [7:0] last_reg = 8'h00;
   wire [7:0] idx = sfr_addr_i[7:0] - 8'h60;
   // unused registers read zero until written
   initial
   begin
      for (int i = 0; i < 160; i++)
         mem[i] = 8'h00;
   end
   // idle cycles show the inverse of the last value so stale data cannot pass
   assign sfr_rdata_o = sfr_rd_i ? mem[idx] : ~last_reg;
   always @(posedge core_clk_i)
   begin
      if (sfr_wr_i)
         mem[idx] <= sfr_wdata_i;
      if (sfr_rd_i)
         last_reg <= mem[idx];
   end
endmodule

// ### bdm_core_asserts.sv
// timing and address checks for the banked data memory block
// assumes it is bound onto bdm_core and sees only its ports
module bdm_core_asserts
#(
   parameter int RAM_BYTES = 768
)
(
   // clock, reset and instruction
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic op_valid_i,
   input wire logic [7:0] op_offset_i,
   input wire logic op_bank_sel_i,
   input wire logic op_rd_i,
   input wire logic op_flags_i,
   input wire logic file_to_file_move_i,
   input wire logic load_bank_literal_i,
   input wire logic [7:0] bank_literal_i,
   input wire logic extended_instruction_enable_i,
   // results
   input wire logic sfr_rd_o,
   input wire logic sfr_wr_o,
   input wire logic [11:0] sfr_addr_o,
   input wire logic [1:0] q_phase_o,
   input wire logic [7:0] rd_data_o,
   input wire logic rd_valid_o,
   input wire logic [11:0] rd_addr_o,
   input wire logic flag_update_o,
   input wire logic [7:0] bank_pointer_reg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire take = q_phase_o == 2'h0 && op_valid_i && !file_to_file_move_i;
   wire [3:0] bank_bits = bank_pointer_reg_o[3:0];
   wire [3:0] lit_bits = bank_literal_i[3:0];
   ////////////////////////////////////////////////////////////////////////////
   a_phase_walk: assert property ($past(rst_n_i) |-> q_phase_o == $past(q_phase_o) + 2'h1)
      else $error("quarter phase did not advance");
   a_rd_in_q3: assert property (rd_valid_o |-> q_phase_o == 2'h2)
      else $error("read result outside Q3");
   a_flag_timing: assert property (take && op_flags_i |-> ##3 flag_update_o)
      else $error("flag update missing in Q4");
   a_flag_only_q4: assert property (flag_update_o |-> q_phase_o == 2'h3)
      else $error("flag update outside Q4");
   a_window_map: assert property (take && op_rd_i && !op_bank_sel_i && !extended_instruction_enable_i
      |-> ##2 rd_valid_o && rd_addr_o == {($past(op_offset_i, 2) < 8'h60) ? 4'h0 : 4'hF,
      $past(op_offset_i, 2)})
      else $error("window address wrong");
   a_banked_addr: assert property (take && op_rd_i && op_bank_sel_i
      |-> ##2 rd_addr_o == {$past(bank_bits, 2), $past(op_offset_i, 2)})
      else $error("banked address wrong");
   a_literal_load: assert property (q_phase_o == 2'h0 && op_valid_i && load_bank_literal_i
      |-> ##4 bank_pointer_reg_o == {4'h0, $past(lit_bits, 4)})
      else $error("bank literal not loaded");
   a_upper_zero: assert property (bank_pointer_reg_o[7:4] == 4'h0 &&
      (!(rd_valid_o && rd_addr_o == 12'hFE0) || rd_data_o == bank_pointer_reg_o))
      else $error("bank pointer upper bits set");
   a_unbuilt_zero: assert property (rd_valid_o && rd_addr_o >= RAM_BYTES && rd_addr_o < 12'hF60
      |-> rd_data_o == 8'h00)
      else $error("unbuilt read not zero");
   a_sfr_rd_when: assert property (sfr_rd_o
      |-> q_phase_o == 2'h1 && sfr_addr_o >= 12'hF60 && sfr_addr_o != 12'hFE0)
      else $error("special read strobe misplaced");
   a_sfr_wr_when: assert property (sfr_wr_o
      |-> q_phase_o == 2'h3 && sfr_addr_o >= 12'hF60 && sfr_addr_o != 12'hFE0)
      else $error("special write strobe misplaced");
endmodule
bind bdm_core bdm_core_asserts #(.RAM_BYTES(RAM_BYTES)) u_asserts (.*);

// ### tb_banked_data_memory_addressing.sv
// self-checking bench for bdm_core with a special register model
// assumes one instruction per four clocks, inputs changed on falling edges
module tb_banked_data_memory_addressing;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, rst_n_i = 1'b0, op_valid_i = 1'b0, op_bank_sel_i = 1'b0;
   logic op_rd_i = 1'b0, op_wr_i = 1'b0, op_flags_i = 1'b0, file_to_file_move_i = 1'b0;
   logic load_bank_literal_i = 1'b0, extended_instruction_enable_i = 1'b0;
   logic [7:0] op_offset_i = 8'h00, op_wr_data_i = 8'h00, bank_literal_i = 8'h00;
   logic [11:0] move_src_addr_i = 12'h000, move_dst_addr_i = 12'h000, idx_base_i = 12'h000;
   wire [7:0] sfr_rdata_i, sfr_wdata_o, rd_data_o, bank_pointer_reg_o;
   wire [11:0] sfr_addr_o, rd_addr_o;
   wire [1:0] q_phase_o;
   wire sfr_rd_o, sfr_wr_o, rd_valid_o, flag_update_o, unimpl_access_o;
   logic [11:0] got_a;
   logic [7:0] got_d;
   logic got_v, got_f, got_u;
   int err_total = 0;
   int tests_run = 0;
   always #5 core_clk_i = ~core_clk_i;
   bdm_core dut (.core_clk_i, .rst_n_i, .op_valid_i, .op_offset_i, .op_bank_sel_i, .op_rd_i,
      .op_wr_i, .op_flags_i, .op_wr_data_i, .file_to_file_move_i, .move_src_addr_i,
      .move_dst_addr_i, .load_bank_literal_i, .bank_literal_i, .extended_instruction_enable_i,
      .idx_base_i, .sfr_rdata_i, .sfr_rd_o, .sfr_wr_o, .sfr_addr_o, .sfr_wdata_o, .q_phase_o,
      .rd_data_o, .rd_valid_o, .rd_addr_o, .flag_update_o, .unimpl_access_o,
      .bank_pointer_reg_o);
   bdm_sfr_model u_sfr (.core_clk_i, .sfr_rd_i(sfr_rd_o), .sfr_wr_i(sfr_wr_o),
      .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   // one whole instruction, held Q1 through Q4; results sampled mid-cycle
   task automatic ins(input logic bs, rd, wr, fl, mv, input logic [7:0] off, d,
      input logic [11:0] src, dst);
      while (q_phase_o !== 2'h0)
         @(negedge core_clk_i);
      op_valid_i = 1'b1;
      op_bank_sel_i = bs;
      op_rd_i = rd;
      op_wr_i = wr;
      op_flags_i = fl;
      file_to_file_move_i = mv;
      op_offset_i = off;
      op_wr_data_i = d;
      move_src_addr_i = src;
      move_dst_addr_i = dst;
      repeat (2) @(negedge core_clk_i);
      got_v = rd_valid_o;
      got_d = rd_data_o;
      got_a = rd_addr_o;
      @(negedge core_clk_i);
      got_f = flag_update_o;
      @(negedge core_clk_i);
      got_u = unimpl_access_o;
      {op_valid_i, op_rd_i, op_wr_i, op_flags_i, file_to_file_move_i} = 5'h00;
      load_bank_literal_i = 1'b0;
      @(negedge core_clk_i);
   endtask
   task automatic lit(input logic [7:0] v);
      load_bank_literal_i = 1'b1;
      bank_literal_i = v;
      ins(0, 0, 0, 0, 0, 8'h00, 8'h00, 12'h000, 12'h000);
   endtask
   task automatic rdchk(input logic bs, input logic [7:0] off, input logic [11:0] a);
      ins(bs, 1, 0, 0, 0, off, 8'h00, 12'h000, 12'h000);
      chk("rd_valid", got_v, 1'b1);
      chk("rd_addr", got_a, a);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #20000;
      err_total++;
      complete_run;
   end
   initial
   begin
      repeat (12) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      lit(8'hF2);
      chk("bank_ptr", bank_pointer_reg_o, 8'h02);
      ins(1, 0, 1, 0, 0, 8'hFF, 8'h5A, 12'h000, 12'h000);
      lit(8'h00);
      ins(1, 0, 1, 0, 0, 8'h05, 8'hC3, 12'h000, 12'h000);
      lit(8'h03);
      // unbuilt bank: write dropped, read zero, flags still move
      ins(1, 1, 1, 1, 0, 8'h10, 8'h77, 12'h000, 12'h000);
      chk("unbuilt_data", got_d, 8'h00);
      chk("unbuilt_flag", got_u, 1'b1);
      chk("flag_update", got_f, 1'b1);
      rdchk(1, 8'h10, 12'h310);
      chk("unbuilt_reread", got_d, 8'h00);
      // window ignores the bank pointer, still 3 here
      rdchk(0, 8'h05, 12'h005);
      chk("window_low", got_d, 8'hC3);
      ins(0, 0, 1, 0, 0, 8'h80, 8'hA5, 12'h000, 12'h000);
      rdchk(0, 8'h80, 12'hF80);
      chk("window_sfr", got_d, 8'hA5);
      rdchk(0, 8'h5F, 12'h05F);
      rdchk(0, 8'h60, 12'hF60);
      ins(0, 1, 1, 0, 1, 8'h00, 8'h3C, 12'h2FF, 12'h100);
      chk("move_src", got_a, 12'h2FF);
      chk("move_data", got_d, 8'h5A);
      lit(8'h01);
      rdchk(1, 8'h00, 12'h100);
      chk("move_dst", got_d, 8'h3C);
      extended_instruction_enable_i = 1'b1;
      idx_base_i = 12'h200;
      rdchk(0, 8'h05, 12'h205);
      rdchk(0, 8'h80, 12'hF80);
      extended_instruction_enable_i = 1'b0;
      // bank pointer as a data register: upper nibble of the write is dropped
      ins(0, 0, 1, 0, 0, 8'hE0, 8'hA7, 12'h000, 12'h000);
      chk("bank_ptr_wr", bank_pointer_reg_o, 8'h07);
      rdchk(0, 8'hE0, 12'hFE0);
      chk("bank_ptr_rd", got_d, 8'h07);
      rst_n_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      chk("bank_ptr_rst", bank_pointer_reg_o, 8'h00);
      rdchk(1, 8'h05, 12'h005);
      chk("ram_kept", got_d, 8'hC3);
      complete_run;
   end
endmodule
